// >>> nvc_pkg.sv
// package for the host-side controller of a nonvolatile static memory port
// assumes a single 250 MHz core clock
package nvc_pkg;
    localparam int CLK_PERIOD_PS       = 4000;
    localparam int ADDR_W              = 20;
    localparam int DATA_W              = 16;
    // device timing figures in their own units
    localparam int T_CYCLE_NS          = 25;    // read and write cycle time
    localparam int T_WRITE_PULSE_NS    = 20;    // write strobe low time
    localparam int T_DATA_HOLD_NS      = 4;     // strobe-off to bus release margin
    localparam int T_GRACE_NS          = 25;    // write_completion_grace
    localparam int T_RESTORE_MS        = 30;    // power_up_restore_time
    localparam int T_SLEEP_ENTRY_MS    = 8;     // sleep_entry_time
    localparam int T_SLEEP_EXIT_MS     = 30;    // sleep_exit_time
    localparam int T_ZZ_LOW_NS         = 50;    // least sleep pin low time
    localparam int T_STORE_PULSE_NS    = 15;    // least store request pulse
    localparam int T_STORE_MS          = 8;     // store cycle duration
    // derived cycle counts: least times round up
    localparam int CYC_CYCLE   = (T_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_WPULSE  = (T_WRITE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_HOLD    = (T_DATA_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_ZZ_LOW  = (T_ZZ_LOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_SPULSE  = (T_STORE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_GRACE   = (T_GRACE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint CYC_PER_MS = 64'd1000000000 / CLK_PERIOD_PS;
    localparam int CYC_RESTORE_DEF = int'(T_RESTORE_MS * CYC_PER_MS);
    localparam int CYC_SLEEP_DEF   = int'(T_SLEEP_ENTRY_MS * CYC_PER_MS);
    localparam int CYC_WAKE_DEF    = int'(T_SLEEP_EXIT_MS * CYC_PER_MS);
    localparam int CYC_STORE_DEF   = int'(T_STORE_MS * CYC_PER_MS);
    localparam int CNT_W = 24;
    // request opcodes
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_STORE = 2'h2;
    localparam logic [1:0] OP_SLEEP = 2'h3;

    typedef enum logic [6:0] {
        NVC_BOOT   = 7'h01,
        NVC_IDLE   = 7'h02,
        NVC_ACCESS = 7'h04,
        NVC_STORE  = 7'h08,
        NVC_SLEEP  = 7'h10,
        NVC_WAKE   = 7'h20,
        NVC_ZZLOW  = 7'h40
    } nvc_state_e;
endpackage

// >>> nvc_cyc_if.sv
// carries one array cycle request from the sequencer to the strobe engine
// assumes both ends share core_clk
`timescale 1ns/1ps
interface nvc_cyc_if;
    import nvc_pkg::*;
    logic              start;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0]        be_n;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rdata;
    modport seq (output start, wr, addr, wdata, be_n, input busy, done, rdata);
    modport eng (input start, wr, addr, wdata, be_n, output busy, done, rdata);
endinterface

// >>> nvc_strobe.sv
// strobe engine: drives one read or write cycle on the memory pins
// assumes the sequencer starts a cycle only while busy is low
`timescale 1ns/1ps
module nvc_strobe
    import nvc_pkg::*;
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // cycle request
    nvc_cyc_if.eng                 cyc,
    // memory strobes
    output logic                   select_low_active,
    output logic                   select_high_active,
    output logic                   write_n,
    output logic                   out_en_n,
    output logic                   lower_byte_sel_n,
    output logic                   upper_byte_sel_n,
    output logic [ADDR_W-1:0]      addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_n,
    input  wire logic [DATA_W-1:0] dq_in
);
    logic [7:0]        cnt, next_cnt;
    logic              act, next_act, wr, next_wr;
    logic              sel, next_sel, we, next_we, oe, next_oe, drv, next_drv;
    logic [1:0]        be, next_be;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] next_dq_out, rd, next_rd;
    logic              dn, next_dn;
    logic [DATA_W-1:0] s1, s2, s3;

    // pin input through three flops; value taken when the last two agree
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end
        else
        begin
            s1 <= dq_in;
            s2 <= s1;
            s3 <= s2;
        end

    always_comb
    begin
        next_cnt = cnt;
        next_act = act;
        next_wr = wr;
        next_sel = sel;
        next_we = we;
        next_oe = oe;
        next_drv = drv;
        next_be = be;
        next_addr = addr;
        next_dq_out = dq_out;
        next_rd = rd;
        next_dn = 1'b0;
        if (!act && cyc.start)
        begin
            // select goes active with write high; write strobe falls later
            next_act = 1'b1;
            next_wr = cyc.wr;
            next_addr = cyc.addr;
            next_be = cyc.be_n;
            next_dq_out = cyc.wdata;
            next_sel = 1'b1;
            next_oe = !cyc.wr;
            next_drv = cyc.wr;
            next_cnt = 8'h00;
        end
        else if (act)
        begin
            next_cnt = cnt + 8'h01;
            if (wr && cnt == 8'h00)
                next_we = 1'b1;
            if (wr && cnt == 8'(CYC_WPULSE))
                next_we = 1'b0;
            if (!wr && cnt == 8'(CYC_CYCLE + 2) && s2 == s3)
                next_rd = s3;
            if (cnt == 8'(CYC_CYCLE + 2))
            begin
                next_sel = 1'b0;
                next_oe = 1'b0;
                next_be = 2'h3;
            end
            if (cnt == 8'(CYC_CYCLE + 2 + CYC_HOLD))
            begin
                next_drv = 1'b0;
                next_act = 1'b0;
                next_dn = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            cnt <= 8'h00;
            act <= 1'b0;
            wr <= 1'b0;
            sel <= 1'b0;
            we <= 1'b0;
            oe <= 1'b0;
            drv <= 1'b0;
            be <= 2'h3;
            addr <= '0;
            dq_out <= '0;
            rd <= '0;
            dn <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            act <= next_act;
            wr <= next_wr;
            sel <= next_sel;
            we <= next_we;
            oe <= next_oe;
            drv <= next_drv;
            be <= next_be;
            addr <= next_addr;
            dq_out <= next_dq_out;
            rd <= next_rd;
            dn <= next_dn;
        end

    // reads never lower the write strobe
    assign write_n = !(we && wr);
    assign select_low_active = !sel;
    assign select_high_active = sel;
    assign out_en_n = !oe;
    assign lower_byte_sel_n = be[0];
    assign upper_byte_sel_n = be[1];
    assign dq_oe_n = !drv;
    assign cyc.busy = act;
    assign cyc.done = dn;
    assign cyc.rdata = rd;
endmodule // nvc_strobe

// >>> nvc_host.sv
// host controller for a nonvolatile static memory: array cycles, pin store, sleep
// assumes power_good comes from a supply monitor outside, asynchronous to core_clk
// What this block does
// - write strobe stays high throughout every read access
// - store request line stays high during ordinary reads and writes
// - host waits 30 ms after sleep pin high before first access
// - host may lower sleep pin right after its last write
`timescale 1ns/1ps
module nvc_host
    import nvc_pkg::*;
#(
    parameter int RESTORE_CYC = CYC_RESTORE_DEF,
    parameter int SLEEP_CYC   = CYC_SLEEP_DEF,
    parameter int WAKE_CYC    = CYC_WAKE_DEF,
    parameter int STORE_CYC   = CYC_STORE_DEF
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst,
    // user request
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire logic [1:0]        req_op,
    input  wire logic [ADDR_W-1:0] req_addr,
    input  wire logic [DATA_W-1:0] req_wdata,
    input  wire logic [1:0]        req_be_n,
    output logic                   rsp_valid,
    output logic [DATA_W-1:0]      rsp_rdata,
    output logic                   asleep,
    input  wire logic              wake,
    // supply monitor
    input  wire logic              power_good,
    // memory pins
    output logic                   select_low_active,
    output logic                   select_high_active,
    output logic                   write_n,
    output logic                   out_en_n,
    output logic                   lower_byte_sel_n,
    output logic                   upper_byte_sel_n,
    output logic [ADDR_W-1:0]      mem_addr,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe_n,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic                   hw_store_request_n_out,
    output logic                   hw_store_request_n_oe_n,
    input  wire logic              hw_store_request_n_in,
    output logic                   sleep_request_n
);
    nvc_cyc_if cyc ();

    nvc_state_e     state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic           pg1, pg2, pg3, pg_ok, next_pg_ok;
    logic           hs1, hs2, hs3, hs_hi, next_hs_hi;
    logic           rsp_v, next_rsp_v;
    logic           sreq, next_sreq;
    logic           zz, next_zz;
    logic           rd_pend, next_rd_pend;
    logic           go, go_wr;

    nvc_strobe u_strobe (
        .core_clk           (core_clk),
        .rst                (rst),
        .cyc                (cyc),
        .select_low_active  (select_low_active),
        .select_high_active (select_high_active),
        .write_n            (write_n),
        .out_en_n           (out_en_n),
        .lower_byte_sel_n   (lower_byte_sel_n),
        .upper_byte_sel_n   (upper_byte_sel_n),
        .addr               (mem_addr),
        .dq_out             (dq_out),
        .dq_oe_n            (dq_oe_n),
        .dq_in              (dq_in)
    );

    // pin and monitor inputs through three flops
    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            pg1 <= 1'b0;
            pg2 <= 1'b0;
            pg3 <= 1'b0;
            hs1 <= 1'b1;
            hs2 <= 1'b1;
            hs3 <= 1'b1;
        end
        else
        begin
            pg1 <= power_good;
            pg2 <= pg1;
            pg3 <= pg2;
            hs1 <= hw_store_request_n_in;
            hs2 <= hs1;
            hs3 <= hs2;
        end

    // ready only when the device is known to take accesses
    assign req_ready = (state == NVC_IDLE) && pg_ok && hs_hi && !cyc.busy;
    assign go = req_valid && req_ready;
    assign go_wr = req_op == OP_WRITE;
    assign cyc.start = go && (req_op == OP_READ || go_wr);
    assign cyc.wr = go_wr;
    assign cyc.addr = req_addr;
    assign cyc.wdata = req_wdata;
    assign cyc.be_n = req_be_n;

    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_pg_ok = pg_ok;
        next_hs_hi = hs_hi;
        next_rsp_v = 1'b0;
        next_sreq = sreq;
        next_zz = zz;
        next_rd_pend = rd_pend;
        if (pg2 == pg3)
            next_pg_ok = pg3;
        if (hs2 == hs3)
            next_hs_hi = hs3;
        // answer only a read; req_op may already name the next request
        if (cyc.done && rd_pend)
            next_rsp_v = 1'b1;
        if (cyc.start)
            next_rd_pend = !go_wr;
        case (state)
            NVC_BOOT:
            begin
                // wait out power-up restore once supply is good
                if (!pg_ok)
                    next_cnt = '0;
                else if (cnt >= CNT_W'(RESTORE_CYC))
                    next_state = NVC_IDLE;
                else
                    next_cnt = cnt + 1'b1;
            end
            NVC_IDLE:
            begin
                next_cnt = '0;
                if (!pg_ok)
                    next_state = NVC_BOOT;
                else if (go && req_op == OP_STORE)
                begin
                    next_sreq = 1'b1;
                    next_state = NVC_STORE;
                end
                else if (go && req_op == OP_SLEEP)
                begin
                    next_zz = 1'b1;
                    next_state = NVC_ZZLOW;
                end
            end
            NVC_STORE:
            begin
                // pulse the store pin then wait; store may be skipped by the device
                next_cnt = cnt + 1'b1;
                if (cnt == CNT_W'(CYC_SPULSE + CYC_GRACE))
                    next_sreq = 1'b0;
                if (cnt >= CNT_W'(STORE_CYC) || (!sreq && hs_hi && cnt > CNT_W'(CYC_SPULSE + CYC_GRACE + 4)))
                    next_state = NVC_IDLE;
            end
            NVC_ZZLOW:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(SLEEP_CYC) && cnt >= CNT_W'(CYC_ZZ_LOW))
                begin
                    next_cnt = '0;
                    next_state = NVC_SLEEP;
                end
            end
            NVC_SLEEP:
                if (wake)
                begin
                    next_zz = 1'b0;
                    next_state = NVC_WAKE;
                end
            NVC_WAKE:
            begin
                next_cnt = cnt + 1'b1;
                if (cnt >= CNT_W'(WAKE_CYC))
                    next_state = NVC_IDLE;
            end
            default:
                next_state = NVC_BOOT;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
        if (rst)
        begin
            state <= NVC_BOOT;
            cnt <= '0;
            pg_ok <= 1'b0;
            hs_hi <= 1'b1;
            rsp_v <= 1'b0;
            sreq <= 1'b0;
            zz <= 1'b0;
            rd_pend <= 1'b0;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            pg_ok <= next_pg_ok;
            hs_hi <= next_hs_hi;
            rsp_v <= next_rsp_v;
            sreq <= next_sreq;
            zz <= next_zz;
            rd_pend <= next_rd_pend;
        end

    // store pin is released (pulled high) except during a store pulse
    assign hw_store_request_n_out = 1'b0;
    assign hw_store_request_n_oe_n = !sreq;
    assign sleep_request_n = !zz;
    assign rsp_valid = rsp_v;
    assign rsp_rdata = cyc.rdata;
    assign asleep = state == NVC_SLEEP;
endmodule // nvc_host

// >>> nvc_host_assertions.sv
// checker on the host pins of the nonvolatile memory controller
// assumes it is bound to nvc_host and sees only its ports
`timescale 1ns/1ps
module nvc_host_assertions
    import nvc_pkg::*;
#(
    parameter int WAKE_CYC = 50
)
(
    // clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // user side
    input wire logic       req_valid,
    input wire logic       req_ready,
    input wire logic [1:0] req_op,
    input wire logic       rsp_valid,
    // memory pins
    input wire logic       select_low_active,
    input wire logic       select_high_active,
    input wire logic       write_n,
    input wire logic       out_en_n,
    input wire logic       dq_oe_n,
    input wire logic       hw_store_request_n_oe_n,
    input wire logic       sleep_request_n
);
    int wake_cnt;
    int next_wake_cnt;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // cycles since the sleep pin went high, saturating
    always_comb
    begin
        next_wake_cnt = wake_cnt;
        if (!sleep_request_n)
            next_wake_cnt = 0;
        else if (wake_cnt < WAKE_CYC)
            next_wake_cnt = wake_cnt + 1;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            wake_cnt <= WAKE_CYC;
        else
            wake_cnt <= next_wake_cnt;
    end

    a_select_pair: assert property (select_low_active != select_high_active)
        else $error("select pins disagree");
    a_read_no_write: assert property (!select_low_active && !out_en_n |-> write_n)
        else $error("write strobe low in a read");
    a_read_answer: assert property (req_valid && req_ready && req_op == OP_READ |-> ##13 rsp_valid)
        else $error("read answer late or missing");
    a_no_bus_clash: assert property (!dq_oe_n |-> out_en_n)
        else $error("host drives data while outputs enabled");
    a_store_pin_idle: assert property (!select_low_active |-> hw_store_request_n_oe_n)
        else $error("store pin pulled during access");
    a_sleep_deselect: assert property (!sleep_request_n |-> select_low_active)
        else $error("access while sleep pin low");
    a_wake_wait: assert property (!select_low_active |-> wake_cnt >= WAKE_CYC)
        else $error("access too soon after wake");
    a_sleep_clean: assert property ($fell(sleep_request_n) |-> write_n && select_low_active)
        else $error("sleep entered inside a write");
endmodule // nvc_host_assertions

bind nvc_host nvc_host_assertions #(.WAKE_CYC(WAKE_CYC)) chk_u (
    .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
    .rsp_valid(rsp_valid), .select_low_active(select_low_active), .select_high_active(select_high_active),
    .write_n(write_n), .out_en_n(out_en_n), .dq_oe_n(dq_oe_n),
    .hw_store_request_n_oe_n(hw_store_request_n_oe_n), .sleep_request_n(sleep_request_n)
);

// >>> nvc_sram_model.sv
// behavioural nonvolatile static memory seen from its pins
// assumes core_clk only as a time base; supply state comes from power_good
`timescale 1ns/1ps
module nvc_sram_model
    import nvc_pkg::*;
#(
    parameter int RECALL_CYC = 40,
    parameter int STORE_CYC  = 30,
    parameter int SLEEP_CYC  = 20
)
(
    // time base and supply
    input  wire logic              core_clk,
    input  wire logic              power_good,
    // memory pins
    input  wire logic              select_low_active,
    input  wire logic              select_high_active,
    input  wire logic              write_n,
    input  wire logic              out_en_n,
    input  wire logic              lower_byte_sel_n,
    input  wire logic              upper_byte_sel_n,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] dq_out,
    output logic      [DATA_W-1:0] dq_in,
    input  wire logic              store_pull_n,
    output logic                   hw_store_request_n,
    input  wire logic              sleep_request_n
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] nv [int];
    logic [DATA_W-1:0] last_q = '0;
    logic [DATA_W-1:0] d;
    logic              dirty = 1'b0;
    logic              storing = 1'b0;
    logic              asleep_dev = 1'b0;
    logic              wr_at_sel = 1'b0;
    logic              blk_pu = 1'b0;
    logic              sel;
    int                busy = 0;
    int                age = 0;
    int                zz_cnt = 0;
    int                store_count = 0;

    assign sel = !select_low_active && select_high_active && !asleep_dev;
    // device holds the store pin low for the whole store
    assign hw_store_request_n = store_pull_n && !storing;

    always @(sel)
    begin
        wr_at_sel = sel && !write_n;
        if (!sel)
            blk_pu = 1'b0;
    end

    always @(core_clk or sel or write_n or out_en_n or mem_addr)
    begin
        if (sel && write_n && !out_en_n && !wr_at_sel && busy == 0 && power_good)
        begin
            last_q = mem.exists(mem_addr) ? mem[mem_addr] : '0;
            dq_in = last_q;
        end
        else
            dq_in = ~last_q;
    end

    always @(posedge write_n)
    begin
        if (sel && power_good && !blk_pu && (busy == 0 || (storing && age < CYC_GRACE)))
        begin
            d = mem.exists(mem_addr) ? mem[mem_addr] : '0;
            if (!lower_byte_sel_n)
                d[7:0] = dq_out[7:0];
            if (!upper_byte_sel_n)
                d[15:8] = dq_out[15:8];
            mem[mem_addr] = d;
            dirty = 1'b1;
        end
    end

    always @(posedge power_good)
    begin
        mem = nv;
        busy = RECALL_CYC;
        blk_pu = sel && !write_n;
    end

    always @(negedge power_good)
    begin
        if (dirty)
        begin
            nv = mem;
            store_count++;
        end
        dirty = 1'b0;
        mem.delete();
    end

    always @(posedge core_clk)
    begin
        if (busy > 0)
        begin
            busy--;
            age++;
            if (busy == 0 && storing)
            begin
                nv = mem;
                dirty = 1'b0;
                storing = 1'b0;
            end
        end
        else if (!store_pull_n && power_good && dirty)
        begin
            busy = STORE_CYC;
            storing = 1'b1;
            age = 0;
            store_count++;
        end
        zz_cnt = sleep_request_n ? 0 : zz_cnt + 1;
        asleep_dev = zz_cnt >= SLEEP_CYC;
    end
endmodule // nvc_sram_model

// >>> nvc_host_tb.sv
// self-checking bench for nvc_host against a behavioural memory
// assumes the checker is bound in from its own file
`timescale 1ns/1ps
module nvc_host_tb;
    import nvc_pkg::*;
    logic                   core_clk;
    logic                   rst;
    logic                   req_valid;
    logic                   wake;
    logic                   power_good;
    logic [1:0]             req_op;
    logic [1:0]             req_be_n;
    logic [ADDR_W-1:0]      req_addr;
    logic [ADDR_W-1:0]      mem_addr;
    logic [DATA_W-1:0]      req_wdata;
    logic [DATA_W-1:0]      rsp_rdata;
    logic [DATA_W-1:0]      dq_out;
    logic [DATA_W-1:0]      dq_in;
    logic [DATA_W-1:0]      d;
    logic [DATA_W-1:0]      ref_mem [int];
    logic [31:0]            rnd;
    logic                   req_ready;
    logic                   rsp_valid;
    logic                   asleep;
    logic                   sl;
    logic                   sh;
    logic                   write_n;
    logic                   out_en_n;
    logic                   lb_n;
    logic                   ub_n;
    logic                   dq_oe_n;
    logic                   st_out;
    logic                   st_oe_n;
    logic                   st_pin;
    logic                   sleep_request_n;
    int                     errors = 0;
    int                     cmp_count = 0;
    int                     seed = 84;
    int                     cycles = 0;
    int                     n;
    int                     k;
    int                     sc;

    nvc_host #(.RESTORE_CYC(50), .SLEEP_CYC(50), .WAKE_CYC(50), .STORE_CYC(50)) dut_u (
        .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready), .req_op(req_op),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_be_n(req_be_n), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .asleep(asleep), .wake(wake), .power_good(power_good),
        .select_low_active(sl), .select_high_active(sh), .write_n(write_n), .out_en_n(out_en_n),
        .lower_byte_sel_n(lb_n), .upper_byte_sel_n(ub_n), .mem_addr(mem_addr), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .dq_in(dq_in), .hw_store_request_n_out(st_out),
        .hw_store_request_n_oe_n(st_oe_n), .hw_store_request_n_in(st_pin), .sleep_request_n(sleep_request_n));

    nvc_sram_model mdl_u (
        .core_clk(core_clk), .power_good(power_good), .select_low_active(sl), .select_high_active(sh),
        .write_n(write_n), .out_en_n(out_en_n), .lower_byte_sel_n(lb_n), .upper_byte_sel_n(ub_n),
        .mem_addr(mem_addr), .dq_out(dq_out), .dq_in(dq_in), .store_pull_n(st_oe_n | st_out),
        .hw_store_request_n(st_pin), .sleep_request_n(sleep_request_n));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic wait_ready;
        n = 0;
        while (req_ready !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        check("req_ready", {31'h0, req_ready}, 32'h1);
    endtask

    task automatic issue(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
                         input logic [1:0] b);
        @(negedge core_clk);
        req_op = op;
        req_addr = a;
        req_wdata = wd;
        req_be_n = b;
        req_valid = 1'b1;
        wait_ready;
        @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
        d = ref_mem.exists(a) ? ref_mem[a] : '0;
        if (op == OP_WRITE)
        begin
            if (!b[0])
                d[7:0] = wd[7:0];
            if (!b[1])
                d[15:8] = wd[15:8];
            ref_mem[a] = d;
        end
        if (op == OP_READ)
        begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 20)
            begin
                @(negedge core_clk);
                n++;
            end
            check("read_latency", n, 12);
            check("rsp_rdata", {16'h0, rsp_rdata}, {16'h0, d});
        end
    endtask

    task automatic read_all;
        for (k = 0; k < 8; k++)
            issue(OP_READ, k[ADDR_W-1:0], 16'h0, 2'h0);
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            stop_test;
        end
    end

    initial
    begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_op = OP_READ;
        req_addr = '0;
        req_wdata = '0;
        req_be_n = 2'h0;
        wake = 1'b0;
        power_good = 1'b0;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        power_good = 1'b1;
        repeat (25) @(negedge core_clk);
        check("boot_ready", {31'h0, req_ready}, 32'h0);
        for (int i = 0; i < 12; i++)
        begin
            rnd = $random(seed);
            issue(OP_WRITE, {17'h0, rnd[2:0]}, rnd[31:16], rnd[5:4]);
        end
        read_all;
        sc = mdl_u.store_count;
        issue(OP_STORE, 20'h0, 16'h0, 2'h0);
        wait_ready;
        check("store_done", mdl_u.store_count, sc + 1);
        issue(OP_STORE, 20'h0, 16'h0, 2'h0);
        wait_ready;
        check("store_skip", mdl_u.store_count, sc + 1);
        issue(OP_WRITE, 20'h3, 16'h5a5a, 2'h0);
        // let the write land, then give the supply sync time to see the drop
        wait_ready;
        @(negedge core_clk);
        power_good = 1'b0;
        repeat (4) @(negedge core_clk);
        req_valid = 1'b1;
        repeat (10)
        begin
            @(negedge core_clk);
            check("low_supply_ready", {31'h0, req_ready}, 32'h0);
        end
        req_valid = 1'b0;
        @(negedge core_clk);
        power_good = 1'b1;
        read_all;
        check("fail_save", mdl_u.store_count, sc + 2);
        issue(OP_WRITE, 20'h1, 16'hc3c3, 2'h0);
        issue(OP_SLEEP, 20'h0, 16'h0, 2'h0);
        n = 0;
        while (asleep !== 1'b1 && n < 400)
        begin
            @(negedge core_clk);
            n++;
        end
        check("asleep", {31'h0, asleep}, 32'h1);
        check("device_asleep", {31'h0, mdl_u.asleep_dev}, 32'h1);
        @(negedge core_clk);
        wake = 1'b1;
        wait_ready;
        wake = 1'b0;
        read_all;
        stop_test;
    end
endmodule // nvc_host_tb
